// ==== hdl/ocd_defines.vh ====
// Constants for the programmable output clock divider: register map,
// field positions and reset values.
// Assumes a 12-bit APB byte address and 32-bit data words.
`ifndef OCD_DEFINES_VH
`define OCD_DEFINES_VH

// ==========================================================================
// Address map
// ==========================================================================
`define OCD_ADDR_W          12
`define OCD_CTRL_ADDR       12'h000
`define OCD_STAT_ADDR       12'h004
// Miscellaneous extension-bus peripheral range: 12'h100 .. 12'h1ff
`define OCD_MISC_PAGE       4'h1
`define OCD_DIV_ADDR        12'h100

// ==========================================================================
// Control register fields
// ==========================================================================
`define OCD_CTRL_CLOCK_OUTPUT_FUNCTION_EN  0
`define OCD_CTRL_XPER_EN    1
`define OCD_CTRL_MISC_EN    2
`define OCD_CTRL_RESET      3'h0

// ==========================================================================
// Status register fields
// ==========================================================================
`define OCD_STAT_RUNNING    0
`define OCD_STAT_BYPASS     1
`define OCD_STAT_REFUSED    2
`define OCD_STAT_LEVEL      3
`define OCD_STAT_FACTOR_LSB 8

// ==========================================================================
// Divider register
// ==========================================================================
`define OCD_DIV_RESET       8'h00

`endif

// ==== hdl/ocd_divider.v ====
// Clock divider core: counts system clock cycles and forms the divided
// output clock, taking a new factor or enable only at a period boundary.
// Assumes factor and enable come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none

module ocd_divider #(
  parameter DIV_W = 8
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             resetn,
  // Requested setting
  input  wire             enable,
  input  wire [DIV_W-1:0] factor,
  // Divider state
  output reg              div_out,
  output reg              bypass,
  output reg              running,
  output reg  [DIV_W-1:0] active_factor
);

  // ========================================================================
  // Period counter
  // ========================================================================
  reg  [DIV_W-1:0] cnt;
  wire [DIV_W-1:0] half;
  wire [DIV_W-1:0] last;
  wire [DIV_W-1:0] cnt_inc;
  wire             boundary;
  wire             next_bypass;

  assign half        = active_factor >> 1;
  assign last        = active_factor - {{(DIV_W-1){1'b0}}, 1'b1};
  assign cnt_inc     = cnt + {{(DIV_W-1){1'b0}}, 1'b1};
  // Factors 0 and 1 both mean the undivided clock
  assign next_bypass = enable && (factor <= {{(DIV_W-1){1'b0}}, 1'b1});
  // In bypass every edge is a boundary, so a change lands at once
  assign boundary    = !running || bypass || (cnt == last);

  // Settings are sampled only here, so the pin shows no runt pulse but the sliver when bypass ends
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt           <= {DIV_W{1'b0}};
      div_out       <= 1'b0;
      bypass        <= 1'b0;
      running       <= 1'b0;
      active_factor <= {DIV_W{1'b0}};
    end else if (boundary) begin
      cnt           <= {DIV_W{1'b0}};
      active_factor <= factor;
      running       <= enable;
      bypass        <= next_bypass;
      div_out       <= enable && !next_bypass;
    end else begin
      cnt           <= cnt_inc;
      div_out       <= (cnt_inc < half);
    end
  end

endmodule // ocd_divider

`default_nettype wire

// ==== hdl/ocd_clock_output.v ====
// Programmable output clock divider: APB register slave plus the pin
// driver for the clock output function on a port pin.
// Assumes APB master on sys_clk and port logic that owns the pin while
// clk_out_oe is low.
`timescale 1ns/100ps
`default_nettype none
`include "ocd_defines.vh"

module ocd_clock_output #(
  parameter DIV_W = 8
) (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    resetn,
  // APB slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`OCD_ADDR_W-1:0]  paddr,
  input  wire [31:0]             pwdata,
  input  wire [3:0]              pstrb,
  output wire                    pready,
  output reg  [31:0]             prdata,
  output reg                     pslverr,
  // Clock output pin
  output wire                    clk_out,
  output wire                    clk_out_oe
);

  // ========================================================================
  // Register state
  // ========================================================================
  // Control bits kept together in one software register
  reg              clock_output_enable_bit;
  reg              on_chip_extension_bus_peripheral_enable_bit;
  reg              misc_on_chip_extension_bus_range_enable_bit;
  // Division factor
  reg  [DIV_W-1:0] output_clock_divider_register;
  // Sticky flag: a factor write was refused while the bus was closed
  reg              div_write_refused;

  // ========================================================================
  // Divider core outputs
  // ========================================================================
  wire             div_out;
  wire             div_bypass;
  wire             div_running;
  wire [DIV_W-1:0] active_factor;

  // ========================================================================
  // APB decode
  // ========================================================================
  wire             apb_setup;
  wire             apb_access;
  wire             apb_write;
  wire             hit_ctrl;
  wire             hit_stat;
  wire             in_misc_range;
  wire             hit_div;
  wire             mapped;
  wire             div_unlocked;
  wire             div_write_ok;
  wire             div_write_bad;
  wire             byte0_en;

  // Zero wait states: every access completes in its first access cycle
  assign pready     = 1'b1;
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_write  = apb_access && pwrite;

  // Core registers sit in the low page
  assign hit_ctrl = (paddr == `OCD_CTRL_ADDR);
  assign hit_stat = (paddr == `OCD_STAT_ADDR);

  // The factor lives in the miscellaneous range, not with the core
  // registers, so the page check comes first
  assign in_misc_range = (paddr[`OCD_ADDR_W-1:8] == `OCD_MISC_PAGE);
  assign hit_div       = in_misc_range && (paddr == `OCD_DIV_ADDR);

  // The miscellaneous range is only visible once opened by software
  assign div_unlocked  = on_chip_extension_bus_peripheral_enable_bit &&
                         misc_on_chip_extension_bus_range_enable_bit;
  assign mapped        = hit_ctrl || hit_stat || hit_div;

  // Byte lane 0 carries every writable bit
  assign byte0_en      = pstrb[0];

  assign div_write_ok  = apb_write && hit_div && div_unlocked;
  assign div_write_bad = apb_write && hit_div && !div_unlocked;

  // ========================================================================
  // Control register
  // ========================================================================
  // Writes take effect at the access edge, the only edge pready is sampled
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clock_output_enable_bit    <= 1'b0;
      on_chip_extension_bus_peripheral_enable_bit <= 1'b0;
      misc_on_chip_extension_bus_range_enable_bit <= 1'b0;
    end else if (apb_write && hit_ctrl && byte0_en) begin
      clock_output_enable_bit    <= pwdata[`OCD_CTRL_CLOCK_OUTPUT_FUNCTION_EN];
      on_chip_extension_bus_peripheral_enable_bit <= pwdata[`OCD_CTRL_XPER_EN];
      misc_on_chip_extension_bus_range_enable_bit <= pwdata[`OCD_CTRL_MISC_EN];
    end
  end

  // ========================================================================
  // Divider register
  // ========================================================================
  // A closed bus leaves the stored factor untouched; reading it answers with an error
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      output_clock_divider_register <= `OCD_DIV_RESET;
    end else if (div_write_ok && byte0_en) begin
      output_clock_divider_register <= pwdata[DIV_W-1:0];
    end
  end

  // ========================================================================
  // Refused-write flag
  // ========================================================================
  // Cleared by writing one to its status bit; a new refusal in the same
  // cycle wins so that no event is lost
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_write_refused <= 1'b0;
    end else if (div_write_bad) begin
      div_write_refused <= 1'b1;
    end else if (apb_write && hit_stat && byte0_en &&
                 pwdata[`OCD_STAT_REFUSED]) begin
      div_write_refused <= 1'b0;
    end
  end

  // ========================================================================
  // Read data and error answer
  // ========================================================================
  reg [31:0] next_prdata;
  reg        next_pslverr;

  // Reserved bits read zero; unmapped and refused accesses report an error
  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (hit_ctrl) begin
      next_prdata[`OCD_CTRL_CLOCK_OUTPUT_FUNCTION_EN] = clock_output_enable_bit;
      next_prdata[`OCD_CTRL_XPER_EN]   = on_chip_extension_bus_peripheral_enable_bit;
      next_prdata[`OCD_CTRL_MISC_EN]   = misc_on_chip_extension_bus_range_enable_bit;
    end else if (hit_stat) begin
      next_prdata[`OCD_STAT_RUNNING] = div_running;
      next_prdata[`OCD_STAT_BYPASS]  = div_bypass;
      next_prdata[`OCD_STAT_REFUSED] = div_write_refused;
      next_prdata[`OCD_STAT_LEVEL]   = div_out;
      next_prdata[`OCD_STAT_FACTOR_LSB +: DIV_W] = active_factor;
    end else if (hit_div) begin
      if (div_unlocked) begin
        next_prdata[DIV_W-1:0] = output_clock_divider_register;
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (!mapped) begin
      next_pslverr = 1'b1;
    end
  end

  // Registered in the setup cycle so the answer is valid in the access cycle
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end else if (apb_access) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ========================================================================
  // Divider core
  // ========================================================================
  // The core follows the enable bit and factor, applying both at a
  // period boundary
  ocd_divider #(
    .DIV_W         (DIV_W)
  ) u_divider (
    .sys_clk       (sys_clk),
    .resetn        (resetn),
    .enable        (clock_output_enable_bit),
    .factor        (output_clock_divider_register),
    .div_out       (div_out),
    .bypass        (div_bypass),
    .running       (div_running),
    .active_factor (active_factor)
  );

  // ========================================================================
  // Pin driver
  // ========================================================================
  // The undivided clock cannot come from a flop, so the pin is a mux of
  // the system clock and the divided flop. Bypass changes only at a rising
  // edge, which keeps the switch aligned to the clock; the one residual
  // sliver is when bypass ends while the clock is high.
  assign clk_out    = div_running && (div_bypass ? sys_clk
                                                 : div_out);
  // Pin released to the port logic while the function is off
  assign clk_out_oe = div_running;

endmodule // ocd_clock_output

`default_nettype wire

// ==== tb/ocd_checker_assertions.sv ====
// Concurrent checks on the ports of the output clock divider top.
// Assumes one clock domain; bound into every instance of the top.
`timescale 1ns/100ps
`default_nettype none
`include "ocd_defines.vh"
// ==========
module ocd_checker #(
  parameter DIV_W = 8
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Pin
  input wire logic        clk_out,
  input wire logic        clk_out_oe
);
  logic [2:0] ctrl_sh;
  wire acc = psel && penable;
  wire ctl_wr = acc && pwrite && paddr == `OCD_CTRL_ADDR && pstrb[0];
  wire div_acc = acc && paddr == `OCD_DIV_ADDR;
  // Shadow of the enables, so the lock state is known without a body
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ctrl_sh <= 3'h0;
    else if (ctl_wr) ctrl_sh <= pwdata[2:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  locked_div_a: assert property (
    div_acc && ctrl_sh[2:1] != 2'h3 |-> pslverr) else $error("locked divider accepted");
  open_div_a: assert property (
    div_acc && ctrl_sh[2:1] == 2'h3 |-> !pslverr) else $error("open divider refused");
  misc_hole_a: assert property (
    acc && paddr[11:8] == `OCD_MISC_PAGE && paddr != `OCD_DIV_ADDR |-> pslverr)
    else $error("hole in misc range answered");
  on_start_a: assert property (
    ctl_wr && pwdata[0] && !ctrl_sh[0] && !clk_out_oe |-> ##[1:2] clk_out_oe)
    else $error("output did not start");
  off_stop_a: assert property (
    ctl_wr && !pwdata[0] |-> ##[1:260] !clk_out_oe) else $error("output did not stop");
  off_quiet_a: assert property (
    !clk_out_oe |-> !clk_out) else $error("clock seen while off");
  stay_off_a: assert property (
    !ctrl_sh[0] && !clk_out_oe |=> !clk_out_oe) else $error("output started unasked");
  idle_bus_a: assert property (
    !acc |-> prdata == 32'h0 && !pslverr) else $error("bus outputs not idle");
  ready_a: assert property (
    acc |-> pready) else $error("access cycle not ready");
  cover property (div_acc && pwrite && !pslverr);
  cover property (div_acc && pslverr);
  cover property ($rose(clk_out_oe));
endmodule // ocd_checker
bind ocd_clock_output ocd_checker #(.DIV_W(DIV_W)) i_chk (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .clk_out(clk_out), .clk_out_oe(clk_out_oe));
`default_nettype wire

// ==== tb/ocd_clk_sink.sv ====
// Behavioural load on the clock output pin: times its edges.
// Assumes a 1 ns time unit; clr starts a fresh measurement.
`timescale 1ns/100ps
`default_nettype none
// ==========
module ocd_clk_sink (
  // Pin and control
  input  wire logic clk_out,
  input  wire logic clr,
  // Measurements in ns, and the count of rising edges
  output var longint period_ns,
  output var longint high_ns,
  output var longint min_period_ns,
  output var int     edges
);
  longint t_rise;
  // First rise after clr only marks time, so no bogus period appears
  always @(posedge clk_out or posedge clr) begin
    if (clr) begin
      edges <= 0;
      min_period_ns <= 64'd1000000;
    end else begin
      if (edges > 0) begin
        period_ns <= $time - t_rise;
        if ($time - t_rise < min_period_ns) min_period_ns <= $time - t_rise;
      end
      t_rise <= $time;
      edges <= edges + 1;
    end
  end
  // High time ends at the fall
  always @(negedge clk_out) high_ns <= $time - t_rise;
endmodule // ocd_clk_sink
`default_nettype wire

// ==== tb/output_clock_divider_tb.sv ====
// Self-checking bench: APB scenarios and pin timing of the divider.
// Assumes the sink model beside the top and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`include "ocd_defines.vh"
// ==========
module output_clock_divider_tb;
  logic        sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  wire  [31:0] prdata;
  wire         pready, pslverr, clk_out, clk_out_oe;
  longint      period_ns, high_ns, min_period_ns;
  int          edges, num_errors = 0, check_count = 0;

  ocd_clock_output #(.DIV_W(8)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .clk_out(clk_out),
    .clk_out_oe(clk_out_oe));
  ocd_clk_sink i_sink (.clk_out(clk_out), .clr(clr), .period_ns(period_ns),
    .high_ns(high_ns), .min_period_ns(min_period_ns), .edges(edges));

  initial forever #12.5 sys_clk = ~sys_clk;
  // ==========
  // Bus and compare tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Waits for pready as long as it takes; a hang is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic [31:0] q;
    logic se;
    apb(1'b1, a, d, q, se);
    chk("write error", {31'h0, e}, {31'h0, se});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic e);
    logic [31:0] q;
    logic se;
    apb(1'b0, a, 32'h0, q, se);
    chk("read error", {31'h0, e}, {31'h0, se});
    chk("read data", x, q & m);
  endtask
  task automatic pulse_clr;
    @(posedge sys_clk) clr <= 1;
    @(posedge sys_clk) clr <= 0;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    rd(`OCD_CTRL_ADDR, 32'h0, 32'h7, 1'b0);
    rd(`OCD_DIV_ADDR, 32'h0, 32'hffffffff, 1'b1);
    chk("oe", 32'h0, {31'h0, clk_out_oe});
    $display("test reset done");
  endtask
  task automatic t_bypass;
    wr(`OCD_CTRL_ADDR, 32'h1, 1'b0);
    pulse_clr;
    repeat (4) @(posedge sys_clk);
    #5 chk("pin high", 32'h1, {31'h0, clk_out});
    #12.5 chk("pin low", 32'h0, {31'h0, clk_out});
    chk("period", 32'd25, 32'(period_ns));
    rd(`OCD_STAT_ADDR, 32'h3, 32'h3, 1'b0);
    $display("test bypass done");
  endtask
  // Locked divider: refused, sticky flag cleared by writing one
  task automatic t_lock;
    wr(`OCD_DIV_ADDR, 32'h4, 1'b1);
    rd(`OCD_STAT_ADDR, 32'h4, 32'h4, 1'b0);
    wr(`OCD_STAT_ADDR, 32'h4, 1'b0);
    rd(`OCD_STAT_ADDR, 32'h0, 32'h4, 1'b0);
    wr(`OCD_CTRL_ADDR, 32'h3, 1'b0);
    wr(`OCD_DIV_ADDR, 32'h4, 1'b1);
    wr(`OCD_CTRL_ADDR, 32'h5, 1'b0);
    wr(`OCD_DIV_ADDR, 32'h4, 1'b1);
    rd(`OCD_STAT_ADDR, 32'h0, 32'hff00, 1'b0);
    $display("test lock done");
  endtask
  task automatic t_divide;
    int n[3] = '{2, 3, 7};
    wr(`OCD_CTRL_ADDR, 32'h7, 1'b0);
    foreach (n[i]) begin
      wr(`OCD_DIV_ADDR, n[i], 1'b0);
      rd(`OCD_DIV_ADDR, n[i], 32'hff, 1'b0);
      repeat (3 * n[i] + 4) @(posedge sys_clk);
      chk("period", 25 * n[i], 32'(period_ns));
      chk("high time", 25 * (n[i] / 2), 32'(high_ns));
      rd(`OCD_STAT_ADDR, n[i] << 8, 32'hff00, 1'b0);
    end
    $display("test divide done");
  endtask
  // Factor changed in mid period must not cut a period short
  task automatic t_runt;
    pulse_clr;
    repeat (9) @(posedge sys_clk);
    wr(`OCD_DIV_ADDR, 32'h3, 1'b0);
    repeat (30) @(posedge sys_clk);
    chk("no short period", 32'h1, {31'h0, min_period_ns >= 75});
    $display("test runt done");
  endtask
  task automatic t_off;
    wr(`OCD_CTRL_ADDR, 32'h6, 1'b0);
    repeat (12) @(posedge sys_clk);
    chk("oe", 32'h0, {31'h0, clk_out_oe});
    pulse_clr;
    repeat (20) @(posedge sys_clk);
    chk("edges", 32'h0, edges);
    rd(`OCD_STAT_ADDR, 32'h0, 32'h1, 1'b0);
    $display("test off done");
  endtask
  task automatic t_unmapped;
    rd(12'h008, 32'h0, 32'hffffffff, 1'b1);
    rd(12'h104, 32'h0, 32'hffffffff, 1'b1);
    wr(12'h1fc, 32'h5, 1'b1);
    rd(`OCD_DIV_ADDR, 32'h3, 32'hff, 1'b0);
    $display("test unmapped done");
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1;
    t_reset;
    t_bypass;
    t_lock;
    t_divide;
    t_runt;
    t_off;
    t_unmapped;
    end_sim;
  end
  // Run needs well under a thousand cycles
  initial begin
    #(25 * 5000);
    num_errors++;
    end_sim;
  end
endmodule // output_clock_divider_tb
`default_nettype wire
